// file: core/mers_pkg.sv
package mers_pkg;

    // ----------------------------------------
    // register map, word indices times four
    // ----------------------------------------
    localparam logic [11:0] MERS_IDX_TRIGGER = 12'h199; // trigger level select
    localparam logic [11:0] MERS_IDX_ALMCLR = 12'h19A; // alarm-clear enable
    localparam logic [11:0] MERS_IDX_CURON = 12'h19B; // current-on enable
    localparam logic [11:0] MERS_IDX_STOP = 12'h19C; // stop enable
    localparam logic [11:0] MERS_IDX_BLANK = 12'h198; // blanking time in ms
    localparam logic [11:0] MERS_IDX_STATUS = 12'h1A0; // status word
    localparam logic [13:0] MERS_ADDR_TRIGGER = {MERS_IDX_TRIGGER, 2'b00};
    localparam logic [13:0] MERS_ADDR_ALMCLR = {MERS_IDX_ALMCLR, 2'b00};
    localparam logic [13:0] MERS_ADDR_CURON = {MERS_IDX_CURON, 2'b00};
    localparam logic [13:0] MERS_ADDR_STOP = {MERS_IDX_STOP, 2'b00};
    localparam logic [13:0] MERS_ADDR_BLANK = {MERS_IDX_BLANK, 2'b00};
    localparam logic [13:0] MERS_ADDR_STATUS = {MERS_IDX_STATUS, 2'b00};

    // ----------------------------------------
    // reset values and encodings
    // ----------------------------------------
    localparam logic [1:0] MERS_TRIG_EDGE = 2'h1; // rising edge judgement
    localparam logic [1:0] MERS_TRIG_LEVEL = 2'h2; // level judgement
    localparam logic [1:0] MERS_RST_TRIGGER = 2'h1;
    localparam logic MERS_RST_ALMCLR = 1'b0;
    localparam logic MERS_RST_CURON = 1'b0;
    localparam logic MERS_RST_STOP = 1'b1;
    localparam logic [6:0] MERS_RST_BLANK = 7'h00;
    localparam logic [6:0] MERS_BLANK_MAX_MS = 7'h64; // 100 ms ceiling

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int MERS_CLK_HZ = 40000000;
    localparam int MERS_MS_US = 1000; // one blanking unit, in us
    localparam int MERS_MS_CYCLES = MERS_CLK_HZ / 1000000 * MERS_MS_US;

    // ----------------------------------------
    // carrier of the restore-capable inputs
    // ----------------------------------------
    typedef struct packed {
        logic restore; // dedicated excitation restore
        logic alarmClear; // alarm clear
        logic currentOn; // current on
        logic stop; // stop
    } mers_inputs_s;

endpackage : mers_pkg

// file: core/mers_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser plus previous sample for edge detect
module mers_sync #(
    parameter int WIDTH = 6
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut,
    output logic [WIDTH-1:0] prevOut
);
    // first stage read only by second stage
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] prev_reg;

    // ----------------------------------------
    // sampling chain
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
            prev_reg <= stage2_reg;
        end
    end

    assign syncOut = stage2_reg;
    assign prevOut = prev_reg;
endmodule : mers_sync

// file: core/mers_top.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
// excitation restore selection behind an ahb-lite register slave
module mers_top #(
    parameter int MS_CYCLES = mers_pkg::MERS_MS_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pins, active high = on
    input wire logic excitation_restore_input,
    input wire logic safe_torque_off_input_a,
    input wire logic safe_torque_off_input_b,
    input wire logic alarm_clear_input,
    input wire logic current_on_input,
    input wire logic stop_input,
    output logic torque_off_monitor_output,
    output logic motorExcited
);
    // ----------------------------------------
    // state types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_OFF = 3'b001, // torque removed
        ST_BLANK = 3'b010, // released, restore ignored
        ST_READY = 3'b100 // released, waiting for restore
    } mers_state_e;

    // ----------------------------------------
    // input synchronisation
    // ----------------------------------------
    logic [5:0] pinRaw; // all pins, outside domain
    logic [5:0] pinNow; // synchronised sample
    logic [5:0] pinPrev; // previous sample
    assign pinRaw = {safe_torque_off_input_a, safe_torque_off_input_b,
                     excitation_restore_input, alarm_clear_input,
                     current_on_input, stop_input};

    mers_sync #(.WIDTH(6)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .asyncIn(pinRaw),
        .syncOut(pinNow),
        .prevOut(pinPrev)
    );

    mers_pkg::mers_inputs_s inNow; // current samples
    mers_pkg::mers_inputs_s inPrev; // prior samples
    mers_pkg::mers_inputs_s inRise; // inactive-to-active
    assign inNow = pinNow[3:0];
    assign inPrev = pinPrev[3:0];
    assign inRise = inNow & ~inPrev;
    wire bothOn = pinNow[5] & pinNow[4]; // both torque-off inputs active

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [1:0] trigSel_reg; // trigger level select
    logic almEn_reg; // alarm-clear path enable
    logic curEn_reg; // current-on path enable
    logic stopEn_reg; // stop path enable
    logic [6:0] blankMs_reg; // blanking time in ms

    // address phase capture
    logic wrPend_reg;
    logic [13:0] addrPend_reg;
    wire addrTake = hsel & hready & htrans[1];

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wrPend_reg <= 1'b0;
            addrPend_reg <= 14'h0000;
        end
        else
        begin
            wrPend_reg <= addrTake & hwrite;
            if (addrTake)
            begin
                addrPend_reg <= haddr[13:0];
            end
        end
    end

    // write decode in data phase
    wire wrTrig = wrPend_reg & (addrPend_reg == mers_pkg::MERS_ADDR_TRIGGER);
    wire wrAlm = wrPend_reg & (addrPend_reg == mers_pkg::MERS_ADDR_ALMCLR);
    wire wrCur = wrPend_reg & (addrPend_reg == mers_pkg::MERS_ADDR_CURON);
    wire wrStop = wrPend_reg & (addrPend_reg == mers_pkg::MERS_ADDR_STOP);
    wire wrBlank = wrPend_reg & (addrPend_reg == mers_pkg::MERS_ADDR_BLANK);
    // only the two legal trigger codes and blanking up to 100 ms are accepted; others keep the old value
    wire trigLegal = (hwdata[31:0] == 32'h00000001) | (hwdata[31:0] == 32'h00000002);
    wire blankLegal = (hwdata[31:7] == 25'h0000000) &
                      (hwdata[6:0] <= mers_pkg::MERS_BLANK_MAX_MS);

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            trigSel_reg <= mers_pkg::MERS_RST_TRIGGER;
            almEn_reg <= mers_pkg::MERS_RST_ALMCLR;
            curEn_reg <= mers_pkg::MERS_RST_CURON;
            stopEn_reg <= mers_pkg::MERS_RST_STOP;
            blankMs_reg <= mers_pkg::MERS_RST_BLANK;
        end
        else
        begin
            if (wrTrig & trigLegal)
            begin
                trigSel_reg <= hwdata[1:0];
            end
            if (wrAlm)
            begin
                almEn_reg <= hwdata[0];
            end
            if (wrCur)
            begin
                curEn_reg <= hwdata[0];
            end
            if (wrStop)
            begin
                stopEn_reg <= hwdata[0];
            end
            if (wrBlank & blankLegal)
            begin
                blankMs_reg <= hwdata[6:0];
            end
        end
    end

    // ----------------------------------------
    // excitation state machine
    // ----------------------------------------
    mers_state_e state_reg;
    mers_state_e state_next;
    logic [6:0] msLeft_reg; // blanking ms remaining
    logic [6:0] msLeft_next;
    logic [31:0] tick_reg; // cycles within current ms
    logic [31:0] tick_next;
    logic excited_reg; // motor excited
    logic excited_next;

    // restore request from the dedicated input, edge or level
    wire restoreHit = (trigSel_reg == mers_pkg::MERS_TRIG_LEVEL) ? inNow.restore
                                                                 : inRise.restore;
    // alternative sources, rising edge only
    wire altHit = (almEn_reg & inRise.alarmClear)
                | (curEn_reg & inRise.currentOn)
                | (stopEn_reg & inRise.stop);
    wire msTick = (tick_reg == 32'(MS_CYCLES - 1));

    always_comb
    begin
        state_next = state_reg;
        msLeft_next = msLeft_reg;
        tick_next = tick_reg;
        excited_next = excited_reg;
        unique case (state_reg)
            ST_OFF:
            begin
                excited_next = 1'b0;
                tick_next = 32'h00000000;
                msLeft_next = blankMs_reg;
                if (bothOn)
                begin
                    state_next = (blankMs_reg == 7'h00) ? ST_READY : ST_BLANK;
                end
            end
            ST_BLANK:
            begin
                // restore-capable inputs ignored here; keeps a stray early edge harmless
                tick_next = msTick ? 32'h00000000 : tick_reg + 32'h00000001;
                if (msTick)
                begin
                    msLeft_next = msLeft_reg - 7'h01;
                    if (msLeft_reg == 7'h01)
                    begin
                        state_next = ST_READY;
                    end
                end
            end
            ST_READY:
            begin
                if (~excited_reg & (restoreHit | altHit))
                begin
                    excited_next = 1'b1;
                end
            end
            default:
            begin
                state_next = ST_OFF;
            end
        endcase
        if (~bothOn)
        begin
            state_next = ST_OFF;
            excited_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_reg <= ST_OFF;
            msLeft_reg <= 7'h00;
            tick_reg <= 32'h00000000;
            excited_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            msLeft_reg <= msLeft_next;
            tick_reg <= tick_next;
            excited_reg <= excited_next;
        end
    end

    // monitor is on while torque stays removed; a restore clears it
    assign torque_off_monitor_output = ~excited_reg;
    assign motorExcited = excited_reg;

    // ----------------------------------------
    // read path and response
    // ----------------------------------------
    logic [31:0] rdata_reg;
    wire [31:0] statusWord = {24'h000000, excited_reg, state_reg, pinNow[5:4], 2'b00};
    wire [31:0] rdSel =
        (haddr[13:0] == mers_pkg::MERS_ADDR_TRIGGER) ? {30'h00000000, trigSel_reg} :
        (haddr[13:0] == mers_pkg::MERS_ADDR_ALMCLR) ? {31'h00000000, almEn_reg} :
        (haddr[13:0] == mers_pkg::MERS_ADDR_CURON) ? {31'h00000000, curEn_reg} :
        (haddr[13:0] == mers_pkg::MERS_ADDR_STOP) ? {31'h00000000, stopEn_reg} :
        (haddr[13:0] == mers_pkg::MERS_ADDR_BLANK) ? {25'h0000000, blankMs_reg} :
        (haddr[13:0] == mers_pkg::MERS_ADDR_STATUS) ? statusWord : 32'h00000000;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rdata_reg <= 32'h00000000;
        end
        else if (addrTake & ~hwrite)
        begin
            rdata_reg <= rdSel;
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_level_restore;
        @(posedge core_clk) disable iff (reset)
        (state_reg == ST_READY && bothOn && trigSel_reg == mers_pkg::MERS_TRIG_LEVEL
         && inNow.restore) |=> excited_reg;
    endproperty
    a_level_restore: assert property (p_level_restore)
        else $error("level restore did not excite");

    property p_trig_legal;
        @(posedge core_clk) disable iff (reset)
        (trigSel_reg == 2'h1) || (trigSel_reg == 2'h2);
    endproperty
    a_trig_legal: assert property (p_trig_legal)
        else $error("trigger select holds illegal code");

    property p_no_edge_in_edge_mode;
        @(posedge core_clk) disable iff (reset)
        (!excited_reg && trigSel_reg == mers_pkg::MERS_TRIG_EDGE && !inRise.restore
         && !altHit) |=> !excited_reg;
    endproperty
    a_no_edge_in_edge_mode: assert property (p_no_edge_in_edge_mode)
        else $error("excited without an edge");

    property p_alarm_path;
        @(posedge core_clk) disable iff (reset)
        (state_reg == ST_READY && bothOn && almEn_reg && inRise.alarmClear) |=> excited_reg;
    endproperty
    a_alarm_path: assert property (p_alarm_path)
        else $error("alarm clear edge ignored");

    property p_curon_path;
        @(posedge core_clk) disable iff (reset)
        (state_reg == ST_READY && bothOn && curEn_reg && inRise.currentOn) |=> excited_reg;
    endproperty
    a_curon_path: assert property (p_curon_path)
        else $error("current on edge ignored");

    property p_stop_path;
        @(posedge core_clk) disable iff (reset)
        (state_reg == ST_READY && bothOn && stopEn_reg && inRise.stop) |=> excited_reg;
    endproperty
    a_stop_path: assert property (p_stop_path)
        else $error("stop edge ignored");

    property p_off_drops;
        @(posedge core_clk) disable iff (reset)
        !bothOn |=> !excited_reg && state_reg == ST_OFF;
    endproperty
    a_off_drops: assert property (p_off_drops)
        else $error("excitation kept without both inputs");

    property p_blank_hold;
        @(posedge core_clk) disable iff (reset)
        state_reg == ST_BLANK |-> !excited_reg;
    endproperty
    a_blank_hold: assert property (p_blank_hold)
        else $error("excited during blanking");

    property p_monitor;
        @(posedge core_clk) disable iff (reset)
        $rose(excited_reg) |-> !torque_off_monitor_output && $past(torque_off_monitor_output);
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("monitor not cleared on restore");

    c_restore: cover property (@(posedge core_clk) disable iff (reset) $rose(excited_reg));
    c_blank: cover property (@(posedge core_clk) disable iff (reset)
        state_reg == ST_BLANK ##1 state_reg == ST_READY);
    c_level: cover property (@(posedge core_clk) disable iff (reset)
        trigSel_reg == mers_pkg::MERS_TRIG_LEVEL && $rose(excited_reg));
endmodule : mers_top

// file: tb/mers_host.sv
`timescale 1ns/10ps
// host controller model: drives the discrete excitation-control pins
module mers_host (
    input wire logic core_clk,
    output logic excitation_restore_input,
    output logic safe_torque_off_input_a,
    output logic safe_torque_off_input_b,
    output logic alarm_clear_input,
    output logic current_on_input,
    output logic stop_input
);
    // ----------------------------------------
    // pin state
    // ----------------------------------------
    mers_pkg::mers_inputs_s pinState; // restore-capable lines
    logic stoA; // torque-off line a
    logic stoB; // torque-off line b

    initial
    begin
        pinState = '0;
        stoA = 1'b0;
        stoB = 1'b0;
    end

    assign excitation_restore_input = pinState.restore;
    assign alarm_clear_input = pinState.alarmClear;
    assign current_on_input = pinState.currentOn;
    assign stop_input = pinState.stop;
    assign safe_torque_off_input_a = stoA;
    assign safe_torque_off_input_b = stoB;

    // ----------------------------------------
    // tasks called by the bench
    // ----------------------------------------
    // settle time after the move, so a restore comes after release
    task automatic setSto(input logic on);
        @(posedge core_clk);
        stoA <= on;
        stoB <= on;
        repeat (6) @(posedge core_clk);
    endtask : setSto

    // drop one torque-off line only; either one removes torque
    task automatic dropOne(input logic lineB);
        @(posedge core_clk);
        if (lineB)
            stoB <= 1'b0;
        else
            stoA <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : dropOne

    // hold one line at a level; index into the carrier
    task automatic setLine(input int idx, input logic lv);
        logic [3:0] mask;
        mask = 4'h1 << idx;
        @(posedge core_clk);
        if (lv)
            pinState <= pinState | mask;
        else
            pinState <= pinState & ~mask;
    endtask : setLine

    // one rise then fall, long enough to pass the synchroniser
    task automatic pulseLine(input int idx);
        setLine(idx, 1'b1);
        repeat (3) @(posedge core_clk);
        setLine(idx, 1'b0);
    endtask : pulseLine
endmodule : mers_host

// file: tb/test_motor_excitation_restore_select.sv
`timescale 1ns/10ps
// bench: register access over ahb-lite, pins through the host model
module test_motor_excitation_restore_select;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic core_clk; // 40 MHz
    logic reset; // sync, active high
    logic hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic restoreIn, stoA, stoB, almIn, curIn, stopIn, monitor, excited;
    int error_cnt = 0; // mismatches
    int tests_run = 0; // comparisons made
    logic [13:0] altAddr [3]; // alarm-clear, current-on, stop enables
    int altIdx [3]; // matching bit of the pin carrier

    // ----------------------------------------
    // instances
    // ----------------------------------------
    // short millisecond so blanking stays cheap in simulation
    mers_top #(.MS_CYCLES(10)) dut_u (
        .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .excitation_restore_input(restoreIn), .safe_torque_off_input_a(stoA),
        .safe_torque_off_input_b(stoB), .alarm_clear_input(almIn),
        .current_on_input(curIn), .stop_input(stopIn),
        .torque_off_monitor_output(monitor), .motorExcited(excited));
    mers_host host_u (
        .core_clk(core_clk), .excitation_restore_input(restoreIn),
        .safe_torque_off_input_a(stoA), .safe_torque_off_input_b(stoB),
        .alarm_clear_input(almIn), .current_on_input(curIn), .stop_input(stopIn));

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        test_done();
    end

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    // single word transfer; waits on hready, never a fixed count
    task automatic busXfer(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {18'h00000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : busXfer

    task automatic checkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : checkWord

    // bounded wait for excitation, then compare both outputs
    task automatic checkExcite(input logic exp);
        for (int i = 0; i < 10 && exp && excited !== 1'b1; i++) @(posedge core_clk);
        checkWord("excited", {31'h0, exp}, {31'h0, excited});
        checkWord("monitor", {31'h0, ~exp}, {31'h0, monitor});
    endtask : checkExcite

    task automatic test_done();
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        reset = 1'b1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        altAddr = '{mers_pkg::MERS_ADDR_ALMCLR, mers_pkg::MERS_ADDR_CURON,
                    mers_pkg::MERS_ADDR_STOP};
        altIdx = '{2, 1, 0};
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        // reset values
        busXfer(0, mers_pkg::MERS_ADDR_TRIGGER, 0); checkWord("trigger", 32'h1, rd);
        checkWord("resp", 32'h0, {31'h0, hresp});
        busXfer(0, mers_pkg::MERS_ADDR_BLANK, 0); checkWord("blank", 32'h0, rd);
        busXfer(0, mers_pkg::MERS_ADDR_ALMCLR, 0); checkWord("alarm en", 32'h0, rd);
        busXfer(0, mers_pkg::MERS_ADDR_CURON, 0); checkWord("current en", 32'h0, rd);
        busXfer(0, mers_pkg::MERS_ADDR_STOP, 0); checkWord("stop en", 32'h1, rd);
        busXfer(0, 14'h0004, 0); checkWord("unmapped", 32'h0, rd);
        checkExcite(0);
        // restore while torque still removed is ignored
        host_u.pulseLine(3);
        repeat (4) @(posedge core_clk);
        checkExcite(0);
        // edge mode: a level already high at release does nothing
        host_u.setLine(3, 1);
        host_u.setSto(1);
        checkExcite(0);
        host_u.setLine(3, 0);
        host_u.pulseLine(3);
        checkExcite(1);
        host_u.dropOne(1'b0);
        checkExcite(0);
        host_u.setSto(0);
        // level mode, and an illegal code left unapplied
        busXfer(1, mers_pkg::MERS_ADDR_TRIGGER, 32'h2);
        busXfer(1, mers_pkg::MERS_ADDR_TRIGGER, 32'h3);
        busXfer(0, mers_pkg::MERS_ADDR_TRIGGER, 0); checkWord("trigger", 32'h2, rd);
        host_u.setLine(3, 1);
        host_u.setSto(1);
        checkExcite(1);
        // status: excited, ready, both torque-off lines on
        busXfer(0, mers_pkg::MERS_ADDR_STATUS, 0); checkWord("status", 32'h000000CC, rd);
        host_u.dropOne(1'b1);
        checkExcite(0);
        // status: off state, only line a still on
        busXfer(0, mers_pkg::MERS_ADDR_STATUS, 0); checkWord("status", 32'h00000018, rd);
        host_u.setSto(0);
        host_u.setLine(3, 0);
        busXfer(1, mers_pkg::MERS_ADDR_TRIGGER, 32'h1);
        // each alternative source: disabled then enabled
        for (int i = 0; i < 3; i++)
        begin
            busXfer(1, altAddr[i], 32'h0);
            host_u.setSto(1);
            host_u.pulseLine(altIdx[i]);
            repeat (4) @(posedge core_clk);
            checkExcite(0);
            busXfer(1, altAddr[i], 32'h1);
            host_u.pulseLine(altIdx[i]);
            checkExcite(1);
            host_u.setSto(0);
        end
        // blanking of 2 units; an over-range write is left unapplied
        busXfer(1, mers_pkg::MERS_ADDR_BLANK, 32'h2);
        busXfer(1, mers_pkg::MERS_ADDR_BLANK, 32'h65);
        busXfer(0, mers_pkg::MERS_ADDR_BLANK, 0); checkWord("blank", 32'h2, rd);
        host_u.setSto(1);
        host_u.pulseLine(3);
        repeat (4) @(posedge core_clk);
        checkExcite(0);
        repeat (20) @(posedge core_clk);
        host_u.pulseLine(3);
        checkExcite(1);
        test_done();
    end
endmodule : test_motor_excitation_restore_select
